// >>> common/zone_monitor_pkg.sv
// package: register map, field layout, timing counts and carrier types
package zone_monitor_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_RATIO1    = 8'h04;
  localparam logic [7:0] OFS_RATIO2    = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_INT_EN    = 8'h10;
  localparam logic [7:0] OFS_INT_CLR   = 8'h14;
  localparam logic [7:0] OFS_SPEED     = 8'h18;
  localparam logic [7:0] OFS_PROF_SEL  = 8'h1C;
  localparam logic [7:0] OFS_PROF_CODE = 8'h20;
  localparam logic [7:0] OFS_PROF_RNG  = 8'h24;
  localparam logic [7:0] OFS_ACTIVE    = 8'h28;
  // control fields
  localparam int CTRL_ENC_EN  = 0;
  localparam int CTRL_REARM   = 1;
  localparam int CTRL_TOL_LSB = 8;
  localparam int PROF_VALID   = 8;
  // status bits
  localparam int ST_MISMATCH = 0;
  localparam int ST_DIRECTION = 1;
  localparam int ST_NO_PROF  = 2;
  localparam int ST_W        = 3;
  // configuration limits and reset values
  localparam logic [5:0] TOL_MAX   = 6'h2D;   // 45 percent
  localparam logic [5:0] TOL_RST   = 6'h19;   // 25 percent
  localparam logic [9:0] RATIO_MIN = 10'h032; // 50 pulses per cm
  localparam logic [9:0] RATIO_MAX = 10'h3E8; // 1000 pulses per cm
  localparam logic [9:0] RATIO_RST = 10'h032;
  localparam int NPROF = 70;
  // speeds in cm/s
  localparam logic [10:0] SPD_LOW  = 11'h00A;  // 10 cm/s
  localparam logic [10:0] SPD_HIGH = 11'h01E;  // 30 cm/s
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1_000_000;
  localparam int TICK_CYC      = MS_NS / CLK_PERIOD_NS;
  localparam int WIN_MS        = 10;        // measurement interval
  localparam int MAX_INPUT_PULSE_RATE = 100_000; // pulses per second
  localparam logic [10:0] WIN_MAX_PULSES =
    11'(MAX_INPUT_PULSE_RATE * WIN_MS / 1000);
  localparam logic [6:0] CM_SCALE = 7'(1000 / WIN_MS);
  localparam int MIS_MID_S  = 60;
  localparam int MIS_HIGH_S = 20;
  localparam int DIR_MS     = 400;
  localparam logic [15:0] MIS_MID_MS  = 16'(MIS_MID_S * 1000);
  localparam logic [15:0] MIS_HIGH_MS = 16'(MIS_HIGH_S * 1000);
  localparam logic [15:0] DIR_LIM_MS  = 16'(DIR_MS);

  typedef struct packed {
    logic        rev;   // reverse direction
    logic [10:0] mag;   // cm/s
  } enc_speed_t;

  typedef struct packed {
    logic               valid;
    logic [7:0]         code;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
  } prof_t;
endpackage

// >>> src/hold_timer.sv
// hold_timer: millisecond counter that reports when a condition outlasts a limit
`timescale 1ns/1ps
module hold_timer
  import zone_monitor_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,    // 1 ms enable
  input  wire logic         run,     // condition being timed
  input  wire logic [W-1:0] limit,
  output logic      [W-1:0] cnt,
  output logic              expired
);
  // elaboration check: the allowances need at least 16 counter bits
  if (W < 16) $error("hold_timer needs W >= 16");

  // counts only while the condition holds; any break restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (tick && cnt != '1) begin
      cnt <= cnt + 1'b1;
    end
  end

  // strictly beyond the allowance
  assign expired = run && (cnt > limit);
endmodule

// >>> src/quad_speed_meter.sv
// quad_speed_meter: quadrature pin sync, pulse count and speed division
`timescale 1ns/1ps
module quad_speed_meter
  import zone_monitor_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       win,       // end of measurement interval
  input  wire logic [9:0] ratio,     // pulses per cm
  input  wire logic       enc_a,     // pin, asynchronous
  input  wire logic       enc_b,     // pin, asynchronous
  output enc_speed_t      speed,
  output logic            speed_vld
);
  logic [2:0]  a_sync, b_sync;   // three-stage pin synchronisers
  logic        a_st, b_st;       // accepted levels
  logic [10:0] pcnt;             // pulses in current interval
  logic        dir_rev;          // direction of last pulse
  logic [16:0] quo;              // dividend shifting into quotient
  logic [9:0]  rem;
  logic [4:0]  step;
  logic        busy, rev_hold;
  logic [11:0] trial;

  // pins pass three flops; a change counts once stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync <= '0;
      b_sync <= '0;
      a_st   <= 1'b0;
      b_st   <= 1'b0;
    end else begin
      a_sync <= {a_sync[1:0], enc_a};
      b_sync <= {b_sync[1:0], enc_b};
      if (a_sync[1] == a_sync[2]) a_st <= a_sync[2];
      if (b_sync[1] == b_sync[2]) b_st <= b_sync[2];
    end
  end

  // count rising a; b high at that moment means reverse phase order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt    <= '0;
      dir_rev <= 1'b0;
    end else if (win) begin
      pcnt <= '0;
    end else if (a_sync[2] && !a_st && a_sync[1]) begin
      dir_rev <= b_st;
      // clamp keeps speed inside the readable limit
      if (pcnt < WIN_MAX_PULSES) pcnt <= pcnt + 1'b1;
    end
  end

  // restoring divider: cm/s = pulses * scale / ratio, 17 steps
  assign trial = {1'b0, rem, quo[16]} - {2'b00, ratio};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quo <= '0; rem <= '0; step <= '0;
      busy <= 1'b0; rev_hold <= 1'b0;
      speed <= '0; speed_vld <= 1'b0;
    end else begin
      speed_vld <= 1'b0;
      if (win) begin
        quo      <= 17'(pcnt) * 17'(CM_SCALE);
        rem      <= '0;
        step     <= 5'd17;
        busy     <= 1'b1;
        rev_hold <= dir_rev;
      end else if (busy) begin
        if (!trial[11]) begin
          rem <= trial[9:0];
          quo <= {quo[15:0], 1'b1};
        end else begin
          rem <= {rem[8:0], quo[16]};
          quo <= {quo[15:0], 1'b0};
        end
        step <= step - 1'b1;
        if (step == 5'd1) busy <= 1'b0;
      end else if (step == 5'd0) begin
        step <= 5'd31; // one-shot publish marker
        speed.mag <= quo[10:0];
        speed.rev <= rev_hold && quo[10:0] != 11'h000;
        speed_vld <= 1'b1;
      end
    end
  end

  sequence s_window;
    win;
  endsequence
  a_speed_publish: assert property (@(posedge pclk) disable iff (!presetn)
    s_window |-> ##[19:20] speed_vld)
    else $error("speed not published after interval");
endmodule

// >>> src/dual_encoder_speed_zone_monitor.sv
// dual_encoder_speed_zone_monitor: encoder cross-check and profile select
//
// Overview of operation
// - two encoder inputs, separate speed each
// - tolerance 0..45 percent, default 25
// - persistent mismatch drives safety outputs off
// - below 10 cm/s mismatch never stops
// - 10..30 cm/s mismatch allowed 60 s
// - 30 cm/s and up, 20 s
// - opposite directions allowed 0.4 s; the code times this only from 10 cm/s
// - larger speed is the reference
// - pulses per cm 50..1000, default 50
// - readable speed is pulse limit over ratio
// - area code plus speed select profile, 70
// - checking off keeps ranges, code only
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dual_encoder_speed_zone_monitor
  import zone_monitor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,  // clock cycles per millisecond
  parameter int AREA_W      = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              enc1_a,
  input  wire logic              enc1_b,
  input  wire logic              enc2_a,
  input  wire logic              enc2_b,
  input  wire logic [AREA_W-1:0] area_sw,
  output logic      [1:0]        safety_output_pair,
  output logic      [6:0]        active_profile,
  output logic                   profile_valid,
  output logic                   irq
);
  // elaboration checks: area code field is 8 bits, tick needs 2 cycles
  if (AREA_W < 1 || AREA_W > 8) $error("AREA_W must be 1..8");
  if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");

  typedef enum logic [0:0] {
    SCAN_SWEEP = 1'b0,
    SCAN_PUBLISH = 1'b1
  } scan_t;

  // configuration registers
  logic        enc_en_ff;        // encoder checking on
  logic [5:0]  tol_ff;           // mismatch tolerance, percent
  logic [9:0]  ratio1_ff, ratio2_ff;
  logic [6:0]  prof_sel_ff;      // table entry written by software
  logic [ST_W-1:0] status_ff, int_en_ff;
  prof_t       prof_mem [NPROF]; // protection region profile table
  // timing
  logic [31:0] tick_cnt_ff;
  logic        tick_ff, win_ff;
  logic [3:0]  win_cnt_ff;
  // encoder results
  enc_speed_t  spd1, spd2;
  logic        vld1, vld2;
  logic signed [15:0] sp1_ff, sp2_ff;   // signed speeds, cm/s
  logic [10:0] mag1, mag2, ref_mag, low_mag;
  logic signed [15:0] ref_spd;
  // checks
  logic        exceed, mis_run, dir_run, mis_exp, dir_exp;
  logic [15:0] mis_lim, mis_cnt, dir_cnt;
  logic        trip_ff;
  logic        rearm;
  // area inputs
  logic [AREA_W-1:0] area_s1, area_s2, area_s3, area_st_ff;
  // profile scan
  scan_t       scan_ff;
  logic [6:0]  scan_idx_ff, hit_idx_ff;
  logic        hit_ff, match;
  // bus
  logic        acc_done, wr, mapped;
  logic [31:0] rdata;

  // 1 ms tick and 10 ms measurement window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
      win_cnt_ff  <= '0;
      win_ff      <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1));
      win_ff  <= 1'b0;
      if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) tick_cnt_ff <= '0;
      else tick_cnt_ff <= tick_cnt_ff + 1'b1;
      if (tick_ff) begin
        if (win_cnt_ff == 4'(WIN_MS - 1)) begin
          win_cnt_ff <= '0;
          win_ff     <= 1'b1;
        end else begin
          win_cnt_ff <= win_cnt_ff + 1'b1;
        end
      end
    end
  end

  // one meter per encoder, each with its own ratio
  quad_speed_meter u_meter1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .win       (win_ff),
    .ratio     (ratio1_ff),
    .enc_a     (enc1_a),
    .enc_b     (enc1_b),
    .speed     (spd1),
    .speed_vld (vld1)
  );
  quad_speed_meter u_meter2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .win       (win_ff),
    .ratio     (ratio2_ff),
    .enc_a     (enc2_a),
    .enc_b     (enc2_b),
    .speed     (spd2),
    .speed_vld (vld2)
  );

  // signed speeds held between intervals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp1_ff <= '0;
      sp2_ff <= '0;
    end else begin
      if (vld1) sp1_ff <= spd1.rev ? -16'(spd1.mag) : 16'(spd1.mag);
      if (vld2) sp2_ff <= spd2.rev ? -16'(spd2.mag) : 16'(spd2.mag);
    end
  end

  // the faster encoder is the reference, sign included
  always_comb begin
    mag1 = sp1_ff[15] ? 11'(-sp1_ff) : sp1_ff[10:0];
    mag2 = sp2_ff[15] ? 11'(-sp2_ff) : sp2_ff[10:0];
    ref_mag = (mag1 >= mag2) ? mag1 : mag2;
    low_mag = (mag1 >= mag2) ? mag2 : mag1;
    ref_spd = (mag1 >= mag2) ? sp1_ff : sp2_ff;
    // (top_readable_speed - bottom_readable_speed) * 100 > tol * bottom_readable_speed
    exceed = (20'(ref_mag - low_mag) * 20'd100)
           > (20'(tol_ff) * 20'(low_mag));
    // below 10 cm/s a mismatch is never timed
    mis_run = enc_en_ff && exceed && (ref_mag >= SPD_LOW);
    mis_lim = (ref_mag >= SPD_HIGH) ? MIS_HIGH_MS
                                    : MIS_MID_MS;
    dir_run = enc_en_ff && (ref_mag >= SPD_LOW) && (mag1 != '0)
            && (mag2 != '0) && (sp1_ff[15] != sp2_ff[15]);
  end

  // timing of the mismatch and direction allowances
  hold_timer u_mis_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_ff),
    .run     (mis_run),
    .limit   (mis_lim),
    .cnt     (mis_cnt),
    .expired (mis_exp)
  );
  hold_timer u_dir_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_ff),
    .run     (dir_run),
    .limit   (DIR_LIM_MS),
    .cnt     (dir_cnt),
    .expired (dir_exp)
  );

  // trip latch: only a rearm write clears it, and a fresh expiry wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_ff <= 1'b0;
    end else if (mis_exp || dir_exp) begin
      trip_ff <= 1'b1;
    end else if (rearm) begin
      trip_ff <= 1'b0;
    end
  end

  // safety outputs off on trip or when no profile applies; the published
  // result is used, as the sweep flag drops at every publish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_output_pair <= 2'b00;
    end else begin
      safety_output_pair <= (trip_ff || mis_exp || dir_exp || !profile_valid)
                          ? 2'b00 : 2'b11;
    end
  end

  // area switch pins: three flops, accepted when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_s1    <= '0;
      area_s2    <= '0;
      area_s3    <= '0;
      area_st_ff <= '0;
    end else begin
      area_s1 <= area_sw;
      area_s2 <= area_s1;
      area_s3 <= area_s2;
      for (int i = 0; i < AREA_W; i++) begin
        if (area_s2[i] == area_s3[i]) area_st_ff[i] <= area_s3[i];
      end
    end
  end

  // with checking off the stored ranges stay but are ignored
  assign match = prof_mem[scan_idx_ff].valid
    && (prof_mem[scan_idx_ff].code == 8'(area_st_ff))
    && (!enc_en_ff || (ref_spd >= prof_mem[scan_idx_ff].lo
                       && ref_spd <= prof_mem[scan_idx_ff].hi));

  // sweep the table one entry a cycle; first match wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_ff     <= SCAN_SWEEP;
      scan_idx_ff <= '0;
      hit_idx_ff  <= '0;
      hit_ff      <= 1'b0;
      active_profile <= '0;
      profile_valid  <= 1'b0;
    end else begin
      case (scan_ff)
        SCAN_SWEEP: begin
          if (match && !hit_ff) begin
            hit_ff     <= 1'b1;
            hit_idx_ff <= scan_idx_ff;
          end
          if (scan_idx_ff == 7'(NPROF - 1)) scan_ff <= SCAN_PUBLISH;
          else scan_idx_ff <= scan_idx_ff + 1'b1;
        end
        SCAN_PUBLISH: begin
          active_profile <= hit_idx_ff;
          profile_valid  <= hit_ff;
          hit_ff         <= 1'b0;
          scan_idx_ff    <= '0;
          scan_ff        <= SCAN_SWEEP;
        end
        default: scan_ff <= SCAN_SWEEP;
      endcase
    end
  end

  // apb: one wait state, answer registered
  assign acc_done = psel && penable && pready;
  assign wr       = acc_done && pwrite && !pslverr;
  assign rearm    = wr && paddr == OFS_CTRL && pwdata[CTRL_REARM];
  always_comb begin
    mapped = 1'b1;
    rdata  = '0;
    case (paddr)
      OFS_CTRL:   rdata = {18'h0_0000, tol_ff, 7'h00, enc_en_ff};
      OFS_RATIO1: rdata = {22'h00_0000, ratio1_ff};
      OFS_RATIO2: rdata = {22'h00_0000, ratio2_ff};
      OFS_STATUS: rdata = {29'h0000_0000, status_ff};
      OFS_INT_EN: rdata = {29'h0000_0000, int_en_ff};
      OFS_INT_CLR: rdata = '0;            // write-only
      OFS_SPEED:  rdata = {sp2_ff, sp1_ff};
      OFS_PROF_SEL: rdata = {25'h000_0000, prof_sel_ff};
      OFS_PROF_CODE: rdata = {23'h00_0000, prof_mem[prof_sel_ff].valid,
                              prof_mem[prof_sel_ff].code};
      OFS_PROF_RNG: rdata = {prof_mem[prof_sel_ff].hi,
                             prof_mem[prof_sel_ff].lo};
      OFS_ACTIVE: rdata = {23'h00_0000, profile_valid, 1'b0,
                           active_profile};
      default:    mapped = 1'b0;
    endcase
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // configuration writes; out-of-range values are refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_en_ff   <= 1'b1;
      tol_ff      <= TOL_RST;
      ratio1_ff   <= RATIO_RST;
      ratio2_ff   <= RATIO_RST;
      prof_sel_ff <= '0;
      int_en_ff   <= '0;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          enc_en_ff <= pwdata[CTRL_ENC_EN];
          if (pwdata[CTRL_TOL_LSB +: 6] <= TOL_MAX)
            tol_ff <= pwdata[CTRL_TOL_LSB +: 6];
        end
        OFS_RATIO1: if (pwdata[9:0] >= RATIO_MIN && pwdata[9:0] <= RATIO_MAX
                        && pwdata[31:10] == '0)
          ratio1_ff <= pwdata[9:0];
        OFS_RATIO2: if (pwdata[9:0] >= RATIO_MIN && pwdata[9:0] <= RATIO_MAX
                        && pwdata[31:10] == '0) ratio2_ff <= pwdata[9:0];
        OFS_PROF_SEL: if (pwdata[6:0] < 7'(NPROF))
                        prof_sel_ff <= pwdata[6:0];
        OFS_INT_EN: int_en_ff <= pwdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // profile table, kept when checking is switched off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPROF; i++) prof_mem[i] <= '0;
    end else if (wr && paddr == OFS_PROF_CODE) begin
      prof_mem[prof_sel_ff].valid <= pwdata[PROF_VALID];
      prof_mem[prof_sel_ff].code  <= pwdata[7:0];
    end else if (wr && paddr == OFS_PROF_RNG) begin
      prof_mem[prof_sel_ff].lo <= pwdata[15:0];
      prof_mem[prof_sel_ff].hi <= pwdata[31:16];
    end
  end

  // sticky status; an event in the clear cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= '0;
      irq       <= 1'b0;
    end else begin
      status_ff <= (status_ff
                    & ~((wr && paddr == OFS_INT_CLR)
                        ? pwdata[ST_W-1:0] : '0))
                   | {scan_ff == SCAN_PUBLISH && !hit_ff, dir_exp, mis_exp};
      irq <= |(status_ff & int_en_ff);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_expiry;
    mis_exp || dir_exp;
  endsequence
  a_trip_outputs_off: assert property (s_expiry |=> ##1
    safety_output_pair == 2'b00)
    else $error("outputs stayed on after expiry");
  a_slow_never_stop: assert property (ref_mag < SPD_LOW |-> !mis_exp)
    else $error("mismatch trip below 10 cm/s");
  a_mid_band_limit: assert property (mis_exp && ref_mag < SPD_HIGH
    |-> mis_cnt > MIS_MID_MS)
    else $error("mid band trip before 60 s");
  a_high_band_limit: assert property (mis_run && ref_mag >= SPD_HIGH
    && mis_cnt == MIS_HIGH_MS + 16'd1 |-> mis_exp)
    else $error("high band mismatch not tripped at 20 s");
  a_dir_limit: assert property (dir_run && dir_cnt == DIR_LIM_MS + 16'd1
    |-> dir_exp ##2 safety_output_pair == 2'b00)
    else $error("direction conflict outlasted 0.4 s");
  a_ref_is_max: assert property (ref_mag >= mag1 && ref_mag >= mag2)
    else $error("reference below one encoder speed");
  a_tol_range: assert property (tol_ff <= TOL_MAX)
    else $error("tolerance beyond 45 percent");
  a_ratio_range: assert property (ratio1_ff >= RATIO_MIN
    && ratio1_ff <= RATIO_MAX && ratio2_ff >= RATIO_MIN
    && ratio2_ff <= RATIO_MAX)
    else $error("pulse ratio out of range");
  a_profile_bound: assert property (profile_valid |->
    active_profile < 7'(NPROF))
    else $error("active profile index out of table");
endmodule

// >>> tb/quad_encoder_model.sv
// quad_encoder_model: one incremental encoder with a programmable step rate
`timescale 1ns/1ps
module quad_encoder_model (
  input  wire logic       pclk,
  input  wire logic [4:0] step,   // cycles per phase step, 0 stands still
  input  wire logic       rev,    // 1 turns the wheel backwards
  output logic            enc_a,
  output logic            enc_b
);
  logic [4:0] cnt_ff;  // cycles spent in the current phase
  logic [1:0] ph_ff;   // quadrature phase position

  // start at a known phase so the pins are never unknown
  initial begin
    cnt_ff = 5'h00;
    ph_ff  = 2'h0;
  end

  // one step every step cycles; the direction decides the phase order
  always @(posedge pclk) begin
    if (step != 5'h00 && cnt_ff + 5'h01 >= step) begin
      cnt_ff <= 5'h00;
      ph_ff  <= rev ? ph_ff - 2'h1 : ph_ff + 2'h1;
    end else if (step != 5'h00) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // forward: a rises while b is low; reverse: a rises while b is high
  assign enc_a = ph_ff[1] ^ ph_ff[0];
  assign enc_b = ph_ff[1];
endmodule

// >>> tb/tb_dual_encoder_speed_zone_monitor.sv
// tb_dual_encoder_speed_zone_monitor: apb driven test of the encoder monitor
`timescale 1ns/1ps
module tb_dual_encoder_speed_zone_monitor;
  import zone_monitor_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, area_sw;
  logic [31:0] pwdata, prdata, q;
  logic        irq, pv, e;     // interrupt, profile valid, last error
  logic [1:0]  outs;           // safety output pair
  logic [6:0]  prof;           // active profile index
  logic [4:0]  st1, st2;       // encoder step rates, 0 stops
  logic        rv1, rv2;       // encoder directions
  logic        a1, b1, a2, b2;
  int          failures, n_tests;

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // short millisecond so that the 400 ms window fits the run
  dual_encoder_speed_zone_monitor #(.TICK_CYCLES(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc1_a(a1), .enc1_b(b1),
    .enc2_a(a2), .enc2_b(b2), .area_sw(area_sw),
    .safety_output_pair(outs), .active_profile(prof),
    .profile_valid(pv), .irq(irq));
  quad_encoder_model enc1_u (.pclk(pclk), .step(st1), .rev(rv1),
    .enc_a(a1), .enc_b(b1));
  quad_encoder_model enc2_u (.pclk(pclk), .step(st2), .rev(rv2),
    .enc_a(a2), .enc_b(b2));

  // verdict and end of run
  task automatic complete_run();
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      $display("FAIL %s expected %h seen %h", nm, x, s);
      failures++;
    end
  endtask

  // one transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      failures++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg%h", a), q, x);
  endtask

  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, x);
    apb(1'b1, a, d);
    rdchk(a, x);
  endtask

  // one table entry: index, area code with valid, speed range
  task automatic tbl(input logic [31:0] i, c, r);
    wrchk(OFS_PROF_SEL, i, i);
    wrchk(OFS_PROF_CODE, c, c);
    wrchk(OFS_PROF_RNG, r, r);
  endtask

  // bounded wait for the safety outputs to reach a level
  task automatic wait_out(input logic [1:0] x, input int n);
    for (int k = 0; k < n && outs !== x; k++) @(posedge pclk);
    chk("outs", 32'(outs), 32'(x));
    if (outs !== x) complete_run();
  endtask

  task automatic spd_ok(input logic [15:0] v);
    chk("speed", 32'(v >= 16'h0020 && v <= 16'h0022), 32'h0000_0001);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, st1, st2, rv1, rv2} = '0;
    failures = 0;
    n_tests = 0;
    area_sw = 8'h03;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(OFS_CTRL, 32'h0000_1901);
    rdchk(OFS_RATIO1, 32'h0000_0032);
    rdchk(OFS_RATIO2, 32'h0000_0032);
    rdchk(OFS_INT_EN, 32'h0000_0000);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk("pslverr", 32'(e), 32'h0000_0001);
    wait_out(2'b00, 5);
    // out of range values leave the old setting in place
    wrchk(OFS_CTRL, 32'h0000_2E01, 32'h0000_1901);
    wrchk(OFS_CTRL, 32'h0000_2D01, 32'h0000_2D01);
    wrchk(OFS_RATIO1, 32'h0000_0031, 32'h0000_0032);
    wrchk(OFS_RATIO2, 32'h0000_03E9, 32'h0000_0032);
    wrchk(OFS_RATIO2, 32'h0000_03E8, 32'h0000_03E8);
    wrchk(OFS_RATIO2, 32'h0000_0032, 32'h0000_0032);
    wrchk(OFS_INT_EN, 32'h0000_0007, 32'h0000_0007);
    tbl(32'h0000_0000, 32'h0000_0103, 32'h000A_FFF6);
    tbl(32'h0000_0001, 32'h0000_0103, 32'h07D0_000B);
    tbl(32'h0000_0002, 32'h0000_010C, 32'h07D0_F830);
    tbl(32'h0000_0003, 32'h0000_0103, 32'hFFF5_F830);
    wait_out(2'b11, 300);
    chk("prof", 32'(prof), 32'h0000_0000);
    chk("irq", 32'(irq), 32'h0000_0001);
    wrchk(OFS_INT_EN, 32'h0000_0000, 32'h0000_0000);
    chk("irq", 32'(irq), 32'h0000_0000);
    apb(1'b1, OFS_INT_CLR, 32'h0000_0007);
    wrchk(OFS_INT_EN, 32'h0000_0007, 32'h0000_0007);
    rdchk(OFS_STATUS, 32'h0000_0000);
    chk("irq", 32'(irq), 32'h0000_0000);
    // both wheels forward at about 33 cm/s
    st1 <= 5'h03;
    st2 <= 5'h03;
    repeat (700) @(posedge pclk);
    apb(1'b0, OFS_SPEED, 32'h0000_0000);
    spd_ok(q[15:0]);
    spd_ok(q[31:16]);
    chk("prof", 32'(prof), 32'h0000_0001);
    area_sw <= 8'h0C;
    repeat (200) @(posedge pclk);
    chk("prof", 32'(prof), 32'h0000_0002);
    area_sw <= 8'h03;
    wrchk(OFS_CTRL, 32'h0000_2D00, 32'h0000_2D00);
    repeat (200) @(posedge pclk);
    chk("prof", 32'(prof), 32'h0000_0000);
    wrchk(OFS_CTRL, 32'h0000_2D01, 32'h0000_2D01);
    // a sweep cut by the area change may have found no profile
    apb(1'b1, OFS_INT_CLR, 32'h0000_0007);
    // opposite directions below 10 cm/s never stop the vehicle
    st1 <= 5'h0F;
    st2 <= 5'h0F;
    rv2 <= 1'b1;
    repeat (12000) @(posedge pclk);
    chk("outs", 32'(outs), 32'h0000_0003);
    rdchk(OFS_STATUS, 32'h0000_0000);
    // opposite directions at speed trip after 400 ms
    st1 <= 5'h03;
    st2 <= 5'h03;
    repeat (7000) @(posedge pclk);
    chk("outs", 32'(outs), 32'h0000_0003);
    wait_out(2'b00, 3000);
    rdchk(OFS_STATUS, 32'h0000_0002);
    chk("irq", 32'(irq), 32'h0000_0001);
    // stop, clear and rearm
    st1 <= 5'h00;
    st2 <= 5'h00;
    repeat (600) @(posedge pclk);
    apb(1'b1, OFS_INT_CLR, 32'h0000_0007);
    apb(1'b1, OFS_CTRL, 32'h0000_2D03);
    wait_out(2'b11, 300);
    chk("irq", 32'(irq), 32'h0000_0000);
    rdchk(OFS_CTRL, 32'h0000_2D01);
    complete_run();
  end
endmodule
